// ### src/tlrms_regmap.sv
`timescale 1ns/1ps
`default_nettype none
module tlrms_regmap #(
  parameter int unsigned RECONFIGURATION_FLAG_TICKS = 8192
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  input wire tlrms_pkg::tlrms_ax_t i_aw,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire tlrms_pkg::tlrms_w_t i_w,
  output logic o_wready,
  // axi4-lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic i_arvalid,
  input wire tlrms_pkg::tlrms_ax_t i_ar,
  output logic o_arready,
  output logic o_rvalid,
  output tlrms_pkg::tlrms_r_t o_r,
  input wire logic i_rready,
  // block outputs
  output logic o_irq,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [9:0] o_pc
);
  import tlrms_pkg::*;

  tlrms_state_t s;
  tlrms_state_t next_s;
  logic [7:0] ram [0:2047];
  logic ram_we;
  logic [10:0] ram_waddr;
  logic tick10;
  logic tick5;
  logic awake;
  logic expire;
  logic [23:0] reconfiguration_flag_limit;

  // ----------------------------------------
  // microprogram store and helpers
  // ----------------------------------------
  // small resident loop; the real microprogram is not part of this block
  function automatic logic [7:0] rom_byte(input logic [9:0] a);
    case (a)
      10'h000: rom_byte = 8'h80;
      10'h001: rom_byte = 8'h10;
      10'h002: rom_byte = 8'h00;
      10'h003: rom_byte = 8'h04;
      10'h004: rom_byte = 8'hC0;
      10'h005: rom_byte = 8'h01;
      10'h006: rom_byte = 8'h40;
      10'h007: rom_byte = 8'h02;
      default: rom_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [9:0] pc_step(input logic [9:0] a);
    pc_step = (a == ROM_LAST) ? 10'h000 : a + 10'h001;
  endfunction

  function automatic logic [7:0] irq_sources(input logic [7:0] st, input logic [7:0] dg);
    irq_sources = {st[ST_RI], 3'h0, dg[DG_EXCESSIVE_NEGATIVE_ACK_FLAG], st[ST_RECONFIGURATION_FLAG], dg[DG_NEWSUCC], st[ST_TA]};
  endfunction

  assign tick10 = (s.div == DIV_LAST);
  assign tick5 = tick10 && s.phase;
  assign awake = (s.own_id != 8'h00) && !s.mode[MD_SWRESET];
  assign reconfiguration_flag_limit = 24'(RECONFIGURATION_FLAG_TICKS) << s.setup_two[1:0];
  assign expire = awake && tick5 && (s.reconfiguration_flag_cnt >= reconfiguration_flag_limit - 24'h000001);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] idx;
    logic mapped;
    logic [7:0] rd;
    logic [7:0] wd;
    next_s = s;
    idx = 3'h0;
    mapped = 1'b0;
    rd = 8'h00;
    wd = 8'h00;
    ram_we = 1'b0;
    ram_waddr = s.addr;
    next_s.cmd_valid = 1'b0;
    next_s.div = tick10 ? 4'h0 : s.div + 4'h1;
    next_s.phase = tick10 ? !s.phase : s.phase;

    // bus channel capture
    if (i_awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.aw_addr = i_aw.addr;
    end
    if (i_wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_held = 1'b1;
      next_s.w_data = i_w.data[7:0];
      next_s.w_lane = i_w.strb[0];
    end
    if (i_arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.ar_addr = i_ar.addr;
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // host write, committed only on the sequencer tick
    if (tick10 && s.aw_held && s.w_held) begin
      idx = s.aw_addr[4:2];
      mapped = (s.aw_addr[11:5] == 7'h00) && (s.aw_addr[1:0] == 2'h0);
      wd = s.w_data;
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped ? RESP_OKAY : RESP_DECERR;
      // narrow writes without lane 0 leave the byte untouched
      if (mapped && s.w_lane) begin
        case (idx)
          IDX_STATUS: next_s.mask = wd & MASK_WRITABLE;
          IDX_DIAG: begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_code = wd;
            if (wd == CMD_CLEAR_FLAGS || wd == CMD_POR_CLEAR) begin
              next_s.status[ST_POR] = 1'b0;
              next_s.status[ST_RECONFIGURATION_FLAG] = 1'b0;
            end
            if (wd == CMD_POR_CLEAR) begin
              next_s.diag[DG_EXCESSIVE_NEGATIVE_ACK_FLAG] = 1'b0;
            end
          end
          IDX_PTR_HI: begin
            next_s.rd_dir = wd[7];
            next_s.auto_step = wd[6];
            next_s.addr[10:8] = wd[2:0];
          end
          IDX_PTR_LO: begin
            next_s.addr[7:0] = wd;
            if (s.rd_dir) begin
              next_s.data = ram[{s.addr[10:8], wd}];
            end
          end
          IDX_DATA: begin
            ram_we = 1'b1;
            next_s.data = wd;
            if (s.auto_step) begin
              next_s.addr = s.addr + 11'h001;
            end
          end
          IDX_SELECT: begin
            next_s.sel7 = wd[7];
            next_s.sel3 = wd[3];
            next_s.sub = wd[2:0];
          end
          IDX_MODE: begin
            next_s.mode = wd[7:2];
            next_s.sub[1:0] = wd[1:0];
          end
          default: begin
            case (s.sub)
              SUB_PROBE: next_s.probe_id = wd;
              SUB_OWN: next_s.own_id = wd;
              SUB_SETUP_ONE: next_s.setup_one = wd & SETUP_ONE_WRITABLE;
              SUB_SETUP_TWO: next_s.setup_two = wd & SETUP_TWO_WRITABLE;
              default: next_s.setup_one = next_s.setup_one; // test register
            endcase
          end
        endcase
      end
    end

    // host read, same tick so read-side clears merge with sequencer sets
    if (tick10 && !s.arready && !s.rvalid) begin
      idx = s.ar_addr[4:2];
      mapped = (s.ar_addr[11:5] == 7'h00) && (s.ar_addr[1:0] == 2'h0);
      rd = 8'h00;
      if (mapped) begin
        case (idx)
          IDX_STATUS: rd = s.status;
          IDX_DIAG: begin
            rd = {s.diag[7:1], 1'b0};
            next_s.diag = s.diag & ~DIAG_READ_CLEAR;
          end
          IDX_PTR_HI: rd = {s.rd_dir, s.auto_step, 3'h0, s.addr[10:8]};
          IDX_PTR_LO: rd = s.addr[7:0];
          IDX_DATA: begin
            rd = s.data;
            if (s.rd_dir && s.auto_step) begin
              next_s.addr = s.addr + 11'h001;
              next_s.data = ram[s.addr + 11'h001];
            end
          end
          IDX_SELECT: rd = {s.sel7, 3'h0, s.sel3, s.sub};
          IDX_MODE: rd = {s.mode, s.sub[1:0]};
          default: begin
            case (s.sub)
              SUB_PROBE: rd = s.probe_id;
              SUB_OWN: rd = s.own_id;
              SUB_SETUP_ONE: rd = s.setup_one;
              SUB_SUCC: begin
                rd = s.succ_id;
                next_s.diag[DG_NEWSUCC] = 1'b0;
              end
              SUB_SETUP_TWO: rd = s.setup_two;
              default: rd = 8'h00;
            endcase
          end
        endcase
      end
      next_s.rvalid = 1'b1;
      next_s.r.data = {24'h000000, rd};
      next_s.r.resp = mapped ? RESP_OKAY : RESP_DECERR;
    end

    // ----------------------------------------
    // microsequencer; its sets follow host clears so a set wins
    // ----------------------------------------
    if (!awake) begin
      // asleep until a non-zero station id; software reset also holds it
      next_s.st = S_FETCH_OP;
      next_s.pc = 10'h000;
      next_s.reconfiguration_flag_cnt = 24'h000000;
      if (s.mode[MD_SWRESET]) begin
        next_s.status = STATUS_RST;
        next_s.diag = 8'h00;
        next_s.succ_id = 8'h00;
      end
    end else if (expire) begin
      next_s.reconfiguration_flag_cnt = 24'h000000;
      next_s.pc = 10'h000;
      next_s.st = S_FETCH_OP;
      next_s.diag[DG_OWN] = 1'b1;
      next_s.status[ST_RECONFIGURATION_FLAG] = 1'b1;
    end else begin
      if (tick5) begin
        next_s.reconfiguration_flag_cnt = s.reconfiguration_flag_cnt + 24'h000001;
      end
      case (s.st)
        S_FETCH_OP: begin
          if (tick10) begin
            next_s.op = rom_byte(s.pc);
            next_s.pc = pc_step(s.pc);
            next_s.st = S_FETCH_IMM;
          end
        end
        S_FETCH_IMM: begin
          if (tick10) begin
            next_s.imm = rom_byte(s.pc);
            next_s.pc = pc_step(s.pc);
            next_s.st = S_EXEC;
          end
        end
        S_EXEC: begin
          if (tick5) begin
            next_s.st = S_FETCH_OP;
            case (s.op[7:6])
              OP_NOP: begin
                next_s.nop_cnt = s.imm;
                next_s.st = S_WAIT;
              end
              OP_JUMP: next_s.pc = {s.op[1:0], s.imm};
              OP_SETF: begin
                next_s.diag = next_s.diag | {s.imm[7:1], 1'b0};
                next_s.status[ST_TA] = next_s.status[ST_TA] | s.op[0];
                next_s.status[ST_TMA] = next_s.status[ST_TMA] | s.op[1];
                next_s.status[ST_RI] = next_s.status[ST_RI] | s.op[2];
              end
              default: begin
                next_s.succ_id = s.imm;
                next_s.diag[DG_NEWSUCC] = 1'b1;
              end
            endcase
          end
        end
        default: begin
          if (tick5) begin
            if (s.nop_cnt == 8'h00) begin
              next_s.st = S_FETCH_OP;
            end else begin
              next_s.nop_cnt = s.nop_cnt - 8'h01;
            end
          end
        end
      endcase
    end

    next_s.irq = |(irq_sources(next_s.status, next_s.diag) & next_s.mask);
    ram_waddr = s.addr;
  end

  // ----------------------------------------
  // state registers and RAM
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.st <= S_FETCH_OP;
      s.status <= STATUS_RST;
      s.mode <= MODE_RST[7:2];
      s.sub <= {1'b0, MODE_RST[1:0]};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (ram_we) begin
      ram[ram_waddr] <= s.w_data;
    end
  end

  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arready;
  assign o_rvalid = s.rvalid;
  assign o_r = s.r;
  assign o_irq = s.irq;
  assign o_cmd_valid = s.cmd_valid;
  assign o_cmd_code = s.cmd_code;
  assign o_pc = s.pc;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence q_tick_gap;
    !tick10 [*8] ##1 !tick10 ##1 tick10;
  endsequence
  sequence q_fetch_pair;
    (s.st == S_FETCH_IMM) ##[1:10] (s.st == S_EXEC);
  endsequence

  property p_tick_period;
    @(posedge i_ref_clk) disable iff (!i_nrst) tick10 |=> q_tick_gap;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("pc tick period wrong");

  property p_exec_on_slow;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (s.st == S_EXEC) && !tick5 && awake && !expire |=> (s.st == S_EXEC);
  endproperty
  a_exec_on_slow: assert property (p_exec_on_slow) else $error("executed off slow tick");

  // a timeout or a sleep legally restarts the fetch, so those cycles are exempt
  property p_fetch_order;
    @(posedge i_ref_clk) disable iff (!i_nrst || expire || !awake)
      (s.st == S_FETCH_OP) && tick10 && awake && !expire |=> q_fetch_pair;
  endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("fetch order broken");

  property p_nop_freeze;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (s.st == S_WAIT) && !expire && awake |=> $stable(s.pc);
  endproperty
  a_nop_freeze: assert property (p_nop_freeze) else $error("pc moved in wait");

  property p_jump;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (s.st == S_EXEC) && tick5 && awake && !expire && (s.op[7:6] == OP_JUMP)
      |=> (s.pc == {$past(s.op[1:0]), $past(s.imm)});
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  property p_reconfiguration_flag;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      expire |=> (s.pc == 10'h000) && s.diag[DG_OWN] && s.status[ST_RECONFIGURATION_FLAG];
  endproperty
  a_reconfiguration_flag: assert property (p_reconfiguration_flag) else $error("timeout did not restart");

  property p_irq_masked;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (s.mask == 8'h00) ##1 (s.mask == 8'h00) |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with zero mask");

  property p_mask_zero_bits;
    @(posedge i_ref_clk) disable iff (!i_nrst) s.mask[6:4] == 3'h0;
  endproperty
  a_mask_zero_bits: assert property (p_mask_zero_bits) else $error("mask bits 6..4 set");

  property p_resp_on_tick;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_bvalid) || $rose(o_rvalid) |-> $past(tick10);
  endproperty
  a_resp_on_tick: assert property (p_resp_on_tick) else $error("access off tick");
endmodule
`default_nettype wire

// ### include/tlrms_pkg.sv
// Operation
// - derive a 10 MHz and a 5 MHz sequencing tick from the multiplier clock
// - program counter steps on the 10 MHz tick, execution on the 5 MHz tick
// - microprogram sits in a 544 by 8 read-only store addressed by the counter
// - each fetch fills an opcode register and an immediate register
// - the latched opcode is decoded and executed in the same step, on the 5 MHz tick
// - no-op runs a timed wait with the program counter frozen
// - jump loads the program counter with the target taken from the store
// - reconfiguration timeout clears the counter and sets own reconfiguration flag
// - offset 00 read gives inhibit, power-on, reconfiguration, acknowledge, available flags
// - offset 01 read gives seven diagnostic flags, top bit first, bit 0 undefined
// - offset 02 holds direction bit, auto-step bit and address bits 10 to 8
// - offset 06 holds reset, chaining, transmit allow, timeouts, backplane, index bits
// - offset 05 holds three index bits plus two free storage bits
// - offset 07 index 0 probe id, 1 own station id, 2 setup one
// - offset 07 index 3 reads successor id, writes go to an all-zero test register
// - setup one: driver mode, four-nak, zero, receive-all, prescaler, slow arbitration
// - setup two: bus timing, zero, multiplier, enhancement, sync suppress, reconfig time
// - the low index bits in offset 06 choose the register behind offset 07
// - host writes pointer high then low; low write latches the full address
// - interrupt is the OR of each interrupt-capable flag gated by its mask bit
package tlrms_pkg;
  // ----------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_DIAG = 3'h1;
  localparam logic [2:0] IDX_PTR_HI = 3'h2;
  localparam logic [2:0] IDX_PTR_LO = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_SELECT = 3'h5;
  localparam logic [2:0] IDX_MODE = 3'h6;
  localparam logic [2:0] IDX_INDEXED = 3'h7;
  localparam logic [2:0] SUB_PROBE = 3'h0;
  localparam logic [2:0] SUB_OWN = 3'h1;
  localparam logic [2:0] SUB_SETUP_ONE = 3'h2;
  localparam logic [2:0] SUB_SUCC = 3'h3;
  localparam logic [2:0] SUB_SETUP_TWO = 3'h4;
  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_WRITABLE = 8'h8F;
  localparam logic [7:0] SETUP_ONE_WRITABLE = 8'hDF;
  localparam logic [7:0] SETUP_TWO_WRITABLE = 8'hBF;
  localparam logic [7:0] STATUS_RST = 8'h91;
  localparam logic [7:0] MODE_RST = 8'h18;
  localparam int ST_RI = 7;
  localparam int ST_POR = 4;
  localparam int ST_RECONFIGURATION_FLAG = 2;
  localparam int ST_TMA = 1;
  localparam int ST_TA = 0;
  localparam int DG_OWN = 7;
  localparam int DG_EXCESSIVE_NEGATIVE_ACK_FLAG = 3;
  localparam int DG_NEWSUCC = 1;
  localparam int MD_SWRESET = 7;
  localparam logic [7:0] DIAG_READ_CLEAR = 8'hF4;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1E;
  localparam logic [7:0] CMD_POR_CLEAR = 8'h0E;
  // ----------------------------------------
  // sequencer timing and microcode
  // ----------------------------------------
  localparam int REF_CLK_MHZ = 100;
  localparam int PC_CLK_MHZ = 10;
  localparam logic [3:0] DIV_LAST = 4'(REF_CLK_MHZ / PC_CLK_MHZ - 1);
  localparam int ROM_WORDS = 544;
  localparam logic [9:0] ROM_LAST = 10'(ROM_WORDS - 1);
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_JUMP = 2'h1;
  localparam logic [1:0] OP_SETF = 2'h2;
  localparam logic [1:0] OP_LDSUCC = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {S_FETCH_OP, S_FETCH_IMM, S_EXEC, S_WAIT} tlrms_seq_t;
  typedef struct packed {logic [11:0] addr; logic [2:0] prot;} tlrms_ax_t;
  typedef struct packed {logic [31:0] data; logic [3:0] strb;} tlrms_w_t;
  typedef struct packed {logic [31:0] data; logic [1:0] resp;} tlrms_r_t;

  typedef struct packed {
    logic awready, wready, arready, bvalid, rvalid, aw_held, w_held;
    logic [11:0] aw_addr, ar_addr;
    logic [7:0] w_data;
    logic w_lane;
    logic [1:0] bresp;
    tlrms_r_t r;
    logic [3:0] div;
    logic phase;
    tlrms_seq_t st;
    logic [9:0] pc;
    logic [7:0] op, imm, nop_cnt;
    logic [23:0] reconfiguration_flag_cnt;
    logic [7:0] status, diag, mask;
    logic rd_dir, auto_step;
    logic [10:0] addr;
    logic [7:0] data;
    logic sel7, sel3;
    logic [2:0] sub;
    logic [7:2] mode;
    logic [7:0] probe_id, own_id, setup_one, setup_two, succ_id, cmd_code;
    logic irq, cmd_valid;
  } tlrms_state_t;
endpackage

// ### tb/tlrms_host.sv
`timescale 1ns/1ps
`default_nettype none
module tlrms_host (
  // clock
  input wire logic i_ref_clk,
  // write channels
  output logic o_awvalid,
  output tlrms_pkg::tlrms_ax_t o_aw,
  input wire logic i_awready,
  output logic o_wvalid,
  output tlrms_pkg::tlrms_w_t o_w,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  output logic o_bready,
  // read channels
  output logic o_arvalid,
  output tlrms_pkg::tlrms_ax_t o_ar,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire tlrms_pkg::tlrms_r_t i_r,
  output logic o_rready
);
  import tlrms_pkg::*;
  initial begin
    o_awvalid = 1'b0;
    o_wvalid = 1'b0;
    o_bready = 1'b0;
    o_arvalid = 1'b0;
    o_rready = 1'b0;
    o_aw = '0;
    o_w = '0;
    o_ar = '0;
  end
  // released payloads are inverted so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge i_ref_clk);
    o_awvalid <= 1'b1;
    o_aw <= '{addr: a, prot: 3'h0};
    o_wvalid <= 1'b1;
    o_w <= '{data: {24'h0, d}, strb: 4'h1};
    o_bready <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_aw <= ~o_aw;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_w <= ~o_w;
      end
      if (i_bvalid) break;
    end
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge i_ref_clk);
    o_arvalid <= 1'b1;
    o_ar <= '{addr: a, prot: 3'h0};
    o_rready <= 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_ar <= ~o_ar;
      end
      if (i_rvalid) break;
    end
    d = i_r.data[7:0];
    r = i_r.resp;
    o_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tlrms_pkg::*;
  logic ref_clk, nrst, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, irq, cv;
  tlrms_ax_t aw, ar;
  tlrms_w_t w;
  tlrms_r_t r;
  logic [1:0] bresp, rsp;
  logic [7:0] cmd_code, d;
  logic [9:0] pc;
  int fail_count, compares, pulses;
  tlrms_host i_host (.i_ref_clk(ref_clk), .o_awvalid(awv), .o_aw(aw), .i_awready(awr),
    .o_wvalid(wv), .o_w(w), .i_wready(wr_rdy), .i_bvalid(bv), .i_bresp(bresp),
    .o_bready(br), .o_arvalid(arv), .o_ar(ar), .i_arready(arr), .i_rvalid(rv),
    .i_r(r), .o_rready(rr));
  tlrms_regmap #(.RECONFIGURATION_FLAG_TICKS(8)) i_dut (.i_ref_clk(ref_clk), .i_nrst(nrst),
    .i_awvalid(awv), .i_aw(aw), .o_awready(awr), .i_wvalid(wv), .i_w(w),
    .o_wready(wr_rdy), .o_bvalid(bv), .o_bresp(bresp), .i_bready(br),
    .i_arvalid(arv), .i_ar(ar), .o_arready(arr), .o_rvalid(rv), .o_r(r),
    .i_rready(rr), .o_irq(irq), .o_cmd_valid(cv), .o_cmd_code(cmd_code), .o_pc(pc));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] v);
    i_host.wr({7'h00, idx, 2'h0}, v, rsp);
  endtask
  task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
    i_host.rd({7'h00, idx, 2'h0}, d, rsp);
    chk({24'h0, d}, {24'h0, exp});
  endtask
  task automatic sub(input logic [2:0] n);
    wr(IDX_SELECT, {5'h00, n});
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cv === 1'b1) pulses++;
  end
  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(IDX_STATUS, STATUS_RST);
    rdc(IDX_DIAG, 8'h00);
    rdc(IDX_MODE, MODE_RST);
    rdc(IDX_SELECT, 8'h00);
    chk(irq, 1'b0);
    done("reset");
    wr(IDX_PTR_HI, 8'hFF);
    rdc(IDX_PTR_HI, 8'hC7);
    wr(IDX_SELECT, 8'hFF);
    rdc(IDX_SELECT, 8'h8F);
    sub(SUB_SETUP_ONE);
    wr(IDX_INDEXED, 8'hFF);
    rdc(IDX_INDEXED, SETUP_ONE_WRITABLE);
    sub(SUB_SETUP_TWO);
    wr(IDX_INDEXED, 8'hFF);
    rdc(IDX_INDEXED, SETUP_TWO_WRITABLE);
    // shorter timeout (32 slow ticks) so it fires within the wait, after the resident loop reaches its successor load
    wr(IDX_INDEXED, 8'h02);
    sub(SUB_PROBE);
    wr(IDX_INDEXED, 8'h3C);
    rdc(IDX_INDEXED, 8'h3C);
    sub(SUB_SUCC);
    wr(IDX_INDEXED, 8'h55);
    rdc(IDX_INDEXED, 8'h00);
    wr(IDX_MODE, 8'h7E);
    rdc(IDX_MODE, 8'h7E);
    rdc(IDX_INDEXED, SETUP_ONE_WRITABLE);
    wr(IDX_MODE, MODE_RST);
    done("fields");
    wr(IDX_STATUS, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(IDX_STATUS, 8'h80);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(IDX_STATUS, 8'h0E);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    done("mask");
    wr(IDX_DIAG, CMD_CLEAR_FLAGS);
    chk(cmd_code, CMD_CLEAR_FLAGS);
    rdc(IDX_STATUS, 8'h81);
    wr(IDX_DIAG, CMD_POR_CLEAR);
    // let the pulse counter see the last pulse before looking
    @(posedge ref_clk);
    chk(pulses, 2);
    done("command");
    // high pointer first, the low write latches the address
    wr(IDX_PTR_HI, 8'h45);
    wr(IDX_PTR_LO, 8'hFF);
    wr(IDX_DATA, 8'hA5);
    wr(IDX_DATA, 8'h5A);
    wr(IDX_PTR_HI, 8'hC5);
    wr(IDX_PTR_LO, 8'hFF);
    rdc(IDX_DATA, 8'hA5);
    rdc(IDX_DATA, 8'h5A);
    rdc(IDX_PTR_HI, 8'hC6);
    done("ram");
    i_host.wr(12'h020, 8'h11, rsp);
    chk(rsp, RESP_DECERR);
    i_host.rd(12'h020, d, rsp);
    chk({d, rsp}, {8'h00, RESP_DECERR});
    i_host.rd(12'h001, d, rsp);
    chk(rsp, RESP_DECERR);
    i_host.rd(12'h018, d, rsp);
    chk({d, rsp}, {MODE_RST, RESP_OKAY});
    done("decode");
    sub(SUB_OWN);
    wr(IDX_INDEXED, 8'h05);
    rdc(IDX_INDEXED, 8'h05);
    repeat (1000) @(posedge ref_clk);
    i_host.rd({7'h00, IDX_DIAG, 2'h0}, d, rsp);
    chk(d & 8'h92, 8'h92);
    sub(SUB_SUCC);
    rdc(IDX_INDEXED, 8'h01);
    done("sequencer");
    wr(IDX_MODE, 8'h83);
    repeat (20) @(posedge ref_clk);
    chk(pc, 10'h000);
    rdc(IDX_STATUS, STATUS_RST);
    rdc(IDX_INDEXED, 8'h00);
    done("soft_reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
